// File: logic/ppr_pkg.sv
// Constants, types and register map of the process PID regulator.
`default_nettype none
package ppr_pkg;
  typedef logic signed [31:0] ppr_w_t;
  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] td;
  } ppr_gain_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b11
  } ppr_state_t;
  // Timing: one regulator tick is 10 ms, so 0.01 s register units equal ticks.
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_MS = 10;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] TD_PER_TICK = 16'(TICK_TIME_MS);
  // Fixed point: 100.0 % is 2**FS_BITS; the integrator keeps I_FRAC extra bits.
  localparam int FS_BITS = 14;
  localparam ppr_w_t FULL_SCALE = 32'sh0000_4000;
  localparam int I_FRAC = 8;
  localparam logic [15:0] PCT_FULL = 16'h03e8;
  localparam logic [15:0] PCT2_FULL = 16'h2710;
  localparam logic [15:0] GAIN_FULL = 16'h03e8;
  // Register indices; the byte address is four times the index.
  localparam logic [4:0] IX_CTRL = 5'h00;
  localparam logic [4:0] IX_FMAX = 5'h01;
  localparam logic [4:0] IX_REV = 5'h02;
  localparam logic [4:0] IX_DB = 5'h03;
  localparam logic [4:0] IX_DCLAMP = 5'h04;
  localparam logic [4:0] IX_RAMP = 5'h05;
  localparam logic [4:0] IX_FBF = 5'h06;
  localparam logic [4:0] IX_OFLT = 5'h07;
  localparam logic [4:0] IX_KP1 = 5'h08;
  localparam logic [4:0] IX_TI1 = 5'h09;
  localparam logic [4:0] IX_TD1 = 5'h0a;
  localparam logic [4:0] IX_KP2 = 5'h0b;
  localparam logic [4:0] IX_TI2 = 5'h0c;
  localparam logic [4:0] IX_TD2 = 5'h0d;
  localparam logic [4:0] IX_THLO = 5'h0e;
  localparam logic [4:0] IX_THHI = 5'h0f;
  localparam logic [4:0] IX_INIT = 5'h10;
  localparam logic [4:0] IX_HOLD = 5'h11;
  localparam logic [4:0] NREG = 5'h12;
  localparam logic [4:0] IX_STAT = 5'h12;
  localparam logic [4:0] IX_OUT = 5'h13;
  // Control register fields.
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_TERM = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  // Reset values.
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_FMAX = 16'h1388;
  localparam logic [15:0] RST_REV = 16'h00c8;
  localparam logic [15:0] RST_DCLAMP = 16'h000a;
  localparam logic [15:0] RST_KP = 16'h00c8;
  localparam logic [15:0] RST_TI = 16'h00c8;
  localparam logic [15:0] RST_THLO = 16'h00c8;
  localparam logic [15:0] RST_THHI = 16'h0320;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  function automatic logic [15:0] reset_value(input logic [4:0] idx);
    case (idx)
      IX_FMAX: return RST_FMAX;
      IX_REV: return RST_REV;
      IX_DCLAMP: return RST_DCLAMP;
      IX_KP1, IX_KP2: return RST_KP;
      IX_TI1, IX_TI2: return RST_TI;
      IX_THLO: return RST_THLO;
      IX_THHI: return RST_THHI;
      IX_CTRL: return RST_CTRL;
      default: return RST_ZERO;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: logic/ppr_top.sv
// Process PID regulator with APB register file, gain scheduling and startup hold.
//
// Functional notes
// - Derivative: full-scale feedback change over one derivative time gives maximum frequency.
// - Negative output magnitude is clamped to the reverse cut-off frequency.
// - Deviation below the deadband stops regulation and holds the output.
// - Derivative contribution is clamped to the programmed derivative limit.
// - Setpoint ramps linearly; a full-scale change takes the ramp time.
// - Feedback passes a first-order low-pass filter before use.
// - Output frequency reference passes its own low-pass filter in the run state; during the hold it is not filtered.
// - A second gain set holds gain, integral time and derivative time.
// - Selector: 0 first set, 1 terminal input, 2 automatic by deviation.
// - Terminal mode: input off selects set one, on selects set two.
// - Automatic mode: deviation below low threshold uses set one.
// - Automatic mode: deviation above high threshold uses set two.
// - Between thresholds every gain and time is interpolated linearly.
// - At start the output is forced to the initial value for the hold time.
// - Gain 100.0 on full-scale deviation gives maximum frequency.
// - Full-scale deviation over one integral time accumulates maximum frequency.
// - Direction 0 raises output when feedback is low; direction 1 lowers it.
`default_nettype none
module ppr_top
  import ppr_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Process side.
  input wire logic run_in,
  input wire logic gain_switch_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] fb_in,
  output var ppr_w_t freq_ref
);

  function automatic ppr_w_t wd(input logic [15:0] v);
    return ppr_w_t'({16'h0000, v});
  endfunction

  // A zero divisor passes the numerator through, which makes a zero time mean "no filter".
  function automatic ppr_w_t qdiv(input ppr_w_t n, input logic [15:0] d);
    return (d == 16'h0000) ? n : n / wd(d);
  endfunction

  function automatic ppr_w_t sat(input ppr_w_t v, input ppr_w_t lo, input ppr_w_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic ppr_w_t to_q(input logic [15:0] v, input logic [15:0] full);
    return qdiv(wd(v) * FULL_SCALE, full);
  endfunction

  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input ppr_w_t num, input logic [15:0] den);
    return 16'(wd(a) + qdiv((wd(b) - wd(a)) * num, den));
  endfunction

  logic [15:0] cfg_q [NREG];
  ppr_state_t st_q;
  ppr_state_t st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [31:0] tcnt_q;
  logic tick_q;
  ppr_w_t sp_q;
  ppr_w_t fbf_q;
  ppr_w_t iacc_q;
  ppr_w_t u_q;
  ppr_w_t of_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Bus decode.
  wire logic [4:0] ridx = paddr[6:2];
  wire logic setup_ph = psel & ~penable;
  wire logic in_map = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00);
  wire logic rd_hit = in_map && (ridx <= IX_OUT);
  wire logic wr_hit = in_map && (ridx < NREG);
  wire logic acc_ok = pwrite ? wr_hit : rd_hit;
  wire logic do_wr = psel & penable & pready_q & pwrite & wr_hit;

  // Configuration fields.
  wire logic dir = cfg_q[IX_CTRL][CTRL_DIR_BIT];
  wire logic [1:0] mode = cfg_q[IX_CTRL][CTRL_MODE_LSB +: 2];
  wire logic [15:0] fmax = cfg_q[IX_FMAX];
  wire logic [15:0] rev_cut = (cfg_q[IX_REV] > fmax) ? fmax : cfg_q[IX_REV];

  // Setpoint ramp with extra fraction bits so long ramps keep their slope.
  wire ppr_w_t sp_tgt = sat(wd(sp_in), 32'sh0, FULL_SCALE) <<< I_FRAC;
  wire ppr_w_t rstep = qdiv(FULL_SCALE <<< I_FRAC, cfg_q[IX_RAMP]);
  wire ppr_w_t sp_d = sp_q + sat(sp_tgt - sp_q, -rstep, rstep);
  wire ppr_w_t sp_w = sp_q >>> I_FRAC;

  // Feedback filter and deviation.
  wire ppr_w_t fb_w = sat(wd(fb_in), 32'sh0, FULL_SCALE);
  wire ppr_w_t fbf_d = fbf_q + qdiv(fb_w - fbf_q, cfg_q[IX_FBF]);
  wire ppr_w_t err = dir ? (fbf_q - sp_w) : (sp_w - fbf_q);
  wire ppr_w_t aerr = (err < 0) ? -err : err;
  wire logic in_db = aerr < to_q(cfg_q[IX_DB], PCT_FULL);

  // Gain scheduling.
  wire ppr_gain_t gs1 = {cfg_q[IX_KP1], cfg_q[IX_TI1], cfg_q[IX_TD1]};
  wire ppr_gain_t gs2 = {cfg_q[IX_KP2], cfg_q[IX_TI2], cfg_q[IX_TD2]};
  wire ppr_w_t thr_lo = to_q(cfg_q[IX_THLO], PCT_FULL);
  wire ppr_w_t thr_hi = to_q(cfg_q[IX_THHI], PCT_FULL);
  // A reversed threshold pair collapses the band rather than dividing by a negative span.
  wire ppr_w_t span = (thr_hi > thr_lo) ? (thr_hi - thr_lo) : 32'sh0;
  wire ppr_w_t lpos = sat(aerr - thr_lo, 32'sh0, span);
  wire logic [15:0] den = span[15:0];
  wire ppr_gain_t gmix = {lerp(gs1.kp, gs2.kp, lpos, den),
                          lerp(gs1.ti, gs2.ti, lpos, den),
                          lerp(gs1.td, gs2.td, lpos, den)};
  wire logic sel2 = ((mode == MODE_TERM) && gain_switch_in) ||
                    ((mode == MODE_AUTO) && (aerr > thr_hi));
  wire logic sel_mix = (mode == MODE_AUTO) && (aerr >= thr_lo) && (aerr <= thr_hi);
  wire ppr_gain_t g = sel_mix ? gmix : (sel2 ? gs2 : gs1);

  // Regulator terms.
  wire ppr_w_t p_term = qdiv(wd(g.kp) * err, GAIN_FULL);
  wire ppr_w_t i_lim = FULL_SCALE <<< I_FRAC;
  wire ppr_w_t i_d = sat(iacc_q + qdiv(err <<< I_FRAC, g.ti), -i_lim, i_lim);
  // Derivative acts on filtered feedback only, so setpoint steps give no kick.
  wire ppr_w_t dfb = dir ? (fbf_d - fbf_q) : (fbf_q - fbf_d);
  wire ppr_w_t d_raw = qdiv(dfb * wd(g.td), TD_PER_TICK);
  wire ppr_w_t d_lim = to_q(cfg_q[IX_DCLAMP], PCT2_FULL);
  wire ppr_w_t d_term = sat(d_raw, -d_lim, d_lim);
  wire ppr_w_t u_pid = sat(p_term + (i_d >>> I_FRAC) + d_term, -FULL_SCALE, FULL_SCALE);
  wire ppr_w_t q_init = to_q(cfg_q[IX_INIT], PCT_FULL);

  // Output frequency in 0.01 Hz and its filter.
  wire ppr_w_t f_raw = (u_q * wd(fmax)) >>> FS_BITS;
  wire ppr_w_t f_sat = sat(f_raw, -wd(rev_cut), wd(fmax));
  wire ppr_w_t of_d = of_q + qdiv(f_sat - of_q, cfg_q[IX_OFLT]);

  wire logic [31:0] stat_w = {27'h0000000, in_db, sel_mix, sel2, st_q};
  wire logic [31:0] rd_val = (ridx == IX_STAT) ? stat_w :
                             (ridx == IX_OUT) ? of_q :
                             (ridx < NREG) ? {16'h0000, cfg_q[ridx]} : 32'h0000_0000;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign freq_ref = of_q;

  // APB answers with one access cycle; unmapped addresses get pslverr.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~acc_ok;
      if (setup_ph)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NREG; i++)
        cfg_q[i] <= reset_value(5'(i));
    end
    else if (do_wr)
      cfg_q[ridx] <= pwdata[15:0];
  end

  // Sample tick.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tcnt_q == 32'(TICK_CYC - 1));
      tcnt_q <= (tcnt_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tcnt_q + 32'h0000_0001;
    end
  end

  // Start sequence.
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE:
      begin
        cnt_d = cfg_q[IX_HOLD];
        if (run_in)
          st_d = (cfg_q[IX_HOLD] == 16'h0000) ? ST_RUN : ST_HOLD;
      end
      ST_HOLD:
      begin
        cnt_d = cnt_q - 16'h0001;
        if (!run_in)
          st_d = ST_IDLE;
        else if (cnt_q <= 16'h0001)
          st_d = ST_RUN;
      end
      ST_RUN:
        if (!run_in)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  // Loop state advances on ticks only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      sp_q <= 32'sh0;
      fbf_q <= 32'sh0;
      iacc_q <= 32'sh0;
      u_q <= 32'sh0;
      of_q <= 32'sh0;
    end
    else if (tick_q)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sp_q <= sp_d;
      fbf_q <= fbf_d;
      if (st_q != ST_RUN)
      begin
        u_q <= (st_d == ST_IDLE) ? 32'sh0 : q_init;
        iacc_q <= (st_d == ST_IDLE) ? 32'sh0 : (q_init <<< I_FRAC);
      end
      else if (!in_db)
      begin
        u_q <= u_pid;
        iacc_q <= i_d;
      end
      if (st_q == ST_IDLE)
        of_q <= 32'sh0;
      else if (st_q == ST_HOLD)
        of_q <= f_sat;
      else
        of_q <= of_d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start;
    tick_q && (st_q == ST_IDLE) && run_in && (cfg_q[IX_HOLD] != 16'h0000);
  endsequence

  sequence s_held;
    (st_q == ST_HOLD) && (u_q == $past(q_init));
  endsequence

  apb_answer_a: assert property (setup_ph |=> pready && (pslverr == !$past(acc_ok)))
    else $error("APB answer missing or wrong");

  startup_hold_a: assert property (s_start |=> s_held)
    else $error("startup hold not entered at initial value");

  rev_limit_a: assert property (
    tick_q && (st_q == ST_RUN) && (cfg_q[IX_OFLT] == 16'h0000)
      |=> (freq_ref >= -wd($past(rev_cut))) && (freq_ref <= wd($past(fmax))))
    else $error("output beyond reverse or maximum limit");

  deadband_hold_a: assert property (
    tick_q && (st_q == ST_RUN) && (st_d == ST_RUN) && in_db
      |=> (u_q == $past(u_q)) && (iacc_q == $past(iacc_q)))
    else $error("regulator moved inside deadband");

  deriv_clamp_a: assert property ((d_term <= d_lim) && (d_term >= -d_lim))
    else $error("derivative term beyond clamp");

  ramp_step_a: assert property (tick_q |=>
    ((sp_q - $past(sp_q)) <= $past(rstep)) && (($past(sp_q) - sp_q) <= $past(rstep)))
    else $error("setpoint step larger than ramp slope");

  mode_none_a: assert property ((mode == MODE_NONE) |-> (g == gs1))
    else $error("mode 0 did not use first gain set");

  term_switch_a: assert property (
    (mode == MODE_TERM) |-> (g == (gain_switch_in ? gs2 : gs1)))
    else $error("terminal mode picked wrong gain set");

  auto_low_a: assert property (((mode == MODE_AUTO) && (aerr < thr_lo)) |-> (g == gs1))
    else $error("small deviation did not use first set");

  auto_high_a: assert property (((mode == MODE_AUTO) && (aerr > thr_hi)) |-> (g == gs2))
    else $error("large deviation did not use second set");

endmodule
`default_nettype wire

// File: tb/ppr_plant_model.sv
// Behavioural process model that turns the frequency reference into a feedback reading.
`default_nettype none
module ppr_plant_model
  import ppr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Loop side.
  input wire ppr_w_t freq_ref,
  input wire logic force_en,
  input wire logic [15:0] force_val,
  output var logic [15:0] fb
);
  ppr_w_t lvl_q;
  // The level drifts with drive speed; a pinned reading keeps expected values exact.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      lvl_q <= '0;
    else if (force_en)
      lvl_q <= ppr_w_t'(force_val);
    else
      lvl_q <= lvl_q + (freq_ref >>> 8);
  // Readings outside the sensor span saturate, as a real transmitter does.
  assign fb = (lvl_q < 0) ? 16'h0000 : (lvl_q > FULL_SCALE) ? 16'h4000 : lvl_q[15:0];
endmodule
`default_nettype wire

// File: tb/test_pid_process_regulator.sv
// Self-checking testbench of the process PID regulator.
`default_nettype none
module test_pid_process_regulator
  import ppr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TC = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_in = 1'b0;
  logic gain_switch_in = 1'b0;
  logic [15:0] sp_in = 16'h0000;
  logic [15:0] fb_in;
  logic [15:0] fb_force = 16'h0000;
  logic fb_force_en = 1'b1;
  ppr_w_t freq_ref;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] rst_tab [18] = '{16'h0000, 16'h1388, 16'h00c8, 16'h0000, 16'h000a, 16'h0000,
    16'h0000, 16'h0000, 16'h00c8, 16'h00c8, 16'h0000, 16'h00c8, 16'h00c8, 16'h0000,
    16'h00c8, 16'h0320, 16'h0000, 16'h0000};

  always #2.5 pclk = ~pclk;

  ppr_top #(.TICK_CYC(TC)) i_ppr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_in(run_in), .gain_switch_in(gain_switch_in),
    .sp_in(sp_in), .fb_in(fb_in), .freq_ref(freq_ref));

  ppr_plant_model i_ppr_plant_model (.pclk(pclk), .presetn(presetn), .freq_ref(freq_ref),
    .force_en(fb_force_en), .force_val(fb_force), .fb(fb_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Holds the whole request until pready is seen high at a rising edge.
  task automatic apb(input logic wr_en, input logic [4:0] ix, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {1'b0, ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t bus answer timed out", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] ix, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, ix, d, q, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask

  task automatic rd(input logic [4:0] ix, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, ix, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, ee}, "read error flag");
  endtask

  task automatic ticks(input int n);
    repeat (n * TC) @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    run_in <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    logic [31:0] q;
    logic e;
    do_reset();
    for (int i = 0; i < 18; i++)
      rd(5'(i), {16'h0, rst_tab[i]}, 1'b0);
    wr(IX_DB, 32'hffff_1234);
    rd(IX_DB, 32'h0000_1234, 1'b0);
    rd(5'h14, 32'h0, 1'b1);
    apb(1'b1, IX_STAT, 32'h1, q, e);
    chk({31'h0, e}, 32'h1, "read-only write accepted");
    $display("test registers done");
    // Deadband of 50 % with 25 % deviation must keep the output at rest.
    do_reset();
    wr(IX_KP1, 32'h0000_03e8);
    wr(IX_DB, 32'h0000_01f4);
    sp_in <= 16'h1000;
    run_in <= 1'b1;
    ticks(4);
    chk(freq_ref, 32'h0, "deadband output moved");
    rd(IX_STAT, 32'h0000_0013, 1'b0);
    sp_in <= 16'h4000;
    ticks(4);
    chk(freq_ref, 32'h0000_1388, "full forward drive");
    $display("test deadband done");
    do_reset();
    wr(IX_KP1, 32'h0000_03e8);
    wr(IX_CTRL, 32'h0000_0001);
    wr(IX_REV, 32'h0000_012c);
    wr(IX_INIT, 32'h0000_01f4);
    wr(IX_HOLD, 32'h0000_0006);
    sp_in <= 16'h4000;
    run_in <= 1'b1;
    ticks(3);
    chk(freq_ref, 32'h0000_09c4, "startup value");
    rd(IX_STAT, 32'h0000_0001, 1'b0);
    ticks(10);
    chk(freq_ref, 32'hffff_fed4, "reverse limit");
    $display("test startup and reverse done");
    wr(IX_CTRL, 32'h0000_0003);
    gain_switch_in <= 1'b1;
    ticks(2);
    rd(IX_STAT, 32'h0000_0007, 1'b0);
    wr(IX_CTRL, 32'h0000_0001);
    ticks(2);
    rd(IX_STAT, 32'h0000_0003, 1'b0);
    gain_switch_in <= 1'b0;
    wr(IX_CTRL, 32'h0000_0003);
    ticks(2);
    rd(IX_STAT, 32'h0000_0003, 1'b0);
    wr(IX_CTRL, 32'h0000_0005);
    ticks(2);
    rd(IX_STAT, 32'h0000_0007, 1'b0);
    sp_in <= 16'h2000;
    ticks(2);
    rd(IX_STAT, 32'h0000_000b, 1'b0);
    sp_in <= 16'h0666;
    ticks(2);
    rd(IX_STAT, 32'h0000_0003, 1'b0);
    $display("test gain sets done");
    run_in <= 1'b0;
    ticks(3);
    chk(freq_ref, 32'h0, "output after stop");
    rd(IX_OUT, 32'h0, 1'b0);
    $display("test stop done");
    end_sim();
  end
endmodule
`default_nettype wire
